// ---- shared/serial_link_pkg.sv ----
// constants, timing and state types for the modem-side serial link
// assumes a single 100 MHz system clock shared by every design file
package serial_link_pkg;
  // system clock rate in hertz
  localparam int CLK_HZ = 100_000_000;
  // default line rate in bits per second
  localparam int BAUD_DEFAULT = 115200;
  // width of every bit-time divisor and counter
  localparam int DIV_W = 16;
  // clock cycles per bit at the default rate
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  // shortest start pulse accepted by rate detection, in cycles
  localparam logic [15:0] MIN_BIT_DIV = 16'h0004;
  // character framing: eight data bits, no parity, one stop bit
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  // receive buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // quiet time before the port powers down again, in milliseconds
  localparam int IDLE_TIME_MS = 10;
  localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);
  // values after reset
  localparam logic MARK_LEVEL = 1'b1;
  localparam logic CTS_RESET = 1'b0;
  // receiver states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_type;
  // transmitter states
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_type;
endpackage : serial_link_pkg

// ---- verilog/sync_fifo.sv ----
// small synchronous fifo with a registered read port
// assumes one clock, depth a power of two, asynchronous active-low reset
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // storage words
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;  // next free slot
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;  // oldest word
  logic [CW-1:0] count_ff, nxt_count;  // words held in storage
  logic out_valid_ff, nxt_out_valid;  // output register holds a word
  logic [WIDTH-1:0] out_data_ff, nxt_out_data;  // output register
  logic push;  // word accepted this cycle
  logic pop;  // word moved to the output register

  // full storage holds the source back
  assign in_ready = (count_ff < CW'(DEPTH));
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  // pointer, count and output register next values
  always_comb begin
    push = in_valid && in_ready;
    pop = (count_ff != '0) && (!out_valid_ff || out_ready);
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + CW'(push) - CW'(pop);
    nxt_out_valid = out_valid_ff;
    nxt_out_data = out_data_ff;
    if (pop) begin
      // refill the output register from storage
      nxt_out_valid = 1'b1;
      nxt_out_data = mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      // consumer took the word and storage is empty
      nxt_out_valid = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      out_valid_ff <= nxt_out_valid;
      out_data_ff <= nxt_out_data;
    end
  end

  // storage write, no reset needed for data words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule : sync_fifo

// ---- verilog/serial_link_auto_shutdown.sv ----
// modem-side serial link: uart toward the terminal, flow control,
// rate detection and serial-port auto shutdown woken by terminal ready
// assumes all pins already at logic level and synchronous to SYS_CLK
//
// Notes on behaviour
// - modem drives cts and rxd, samples rts txd dtr
// - data lines always used, handshake lines optional
// - flow control off means rts ignored and cts held high, dtr still used
// - autobaud measures start bit, adopts terminal rate
// - port powers down when no traffic flows
// - enter and exit commands switch shutdown mode
// - mode change acts in the accepting cycle
// - rising terminal ready wakes the port
// - grounded cable detect means cable attached
// - default 115200 baud, 8n1, hardware flow
`timescale 1ns/10ps
module serial_link_auto_shutdown #(
  parameter int IDLE_CYCLES = serial_link_pkg::IDLE_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // terminal pins
  input wire logic SERIAL_DATA_FROM_TERMINAL,
  input wire logic REQUEST_TO_SEND_IN,
  input wire logic TERMINAL_READY_IN,
  input wire logic CABLE_DETECT_N,
  output logic SERIAL_DATA_TO_TERMINAL,
  output logic CLEAR_TO_SEND_OUT,
  // configuration from the command layer
  input wire logic FLOW_CONTROL_EN,
  input wire logic AUTOBAUD_EN,
  input wire logic [15:0] FIXED_BAUD_DIV,
  input wire logic SHUTDOWN_ENTER,
  input wire logic SHUTDOWN_EXIT,
  // characters toward the terminal
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  output logic TX_READY,
  // characters from the terminal
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [7:0] RX_DATA,
  // status
  output logic RESERVED_SHUTDOWN_LINE,
  output logic AUTO_SHUTDOWN_MODE,
  output logic CABLE_ATTACHED,
  output logic BAUD_LOCKED,
  output logic [15:0] BAUD_DIV,
  output logic FRAME_ERROR,
  output logic OVERRUN
);
  // reload value for a full bit time
  function automatic logic [15:0] bit_reload(input logic [15:0] div);
    bit_reload = div - 16'h0001;
  endfunction : bit_reload

  // reload value for half a bit time, to sample mid bit
  function automatic logic [15:0] half_reload(input logic [15:0] div);
    half_reload = {1'b0, div[15:1]};
  endfunction : half_reload

  logic rxd;  // terminal's transmit line as seen here
  assign rxd = SERIAL_DATA_FROM_TERMINAL;

  // shutdown group
  logic mode_ff, nxt_mode;  // auto shutdown mode armed
  logic shut_ff, nxt_shut;  // port powered down
  logic [31:0] idle_ff, nxt_idle;  // quiet cycles seen
  logic dtr_prev_ff, nxt_dtr_prev;  // terminal ready last cycle
  logic cable_ff, nxt_cable;  // cable present
  logic cts_ff, nxt_cts;  // clear to send pin
  logic activity;  // any traffic this cycle
  // autobaud group
  logic lock_ff, nxt_lock;  // rate adopted
  logic meas_ff, nxt_meas;  // measuring a start bit
  logic [15:0] meas_cnt_ff, nxt_meas_cnt;  // cycles low so far
  logic [15:0] div_ff, nxt_div;  // cycles per bit in use
  // receiver group
  serial_link_pkg::rx_state_type rx_state_ff, nxt_rx_state;
  logic [15:0] rx_cnt_ff, nxt_rx_cnt;  // bit-time countdown
  logic [2:0] rx_bits_ff, nxt_rx_bits;  // data bit index
  logic [7:0] rx_shift_ff, nxt_rx_shift;  // assembling character
  logic ferr_ff, nxt_ferr;  // stop bit was low
  logic ovr_ff, nxt_ovr;  // character dropped, buffer full
  logic rx_push;  // character complete and good
  logic rx_en;  // receiver may start
  logic fifo_in_ready;  // buffer can take a character
  // transmitter group
  serial_link_pkg::tx_state_type tx_state_ff, nxt_tx_state;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt;  // bit-time countdown
  logic [2:0] tx_bits_ff, nxt_tx_bits;  // data bit index
  logic [7:0] tx_shift_ff, nxt_tx_shift;  // bits still to send
  logic txd_ff, nxt_txd;  // line toward the terminal
  logic tx_ready_ff, nxt_tx_ready;  // may accept a character

  // shutdown mode, wake and idle timing
  always_comb begin
    activity = !rxd || meas_ff || (rx_state_ff != serial_link_pkg::RX_IDLE)
             || (tx_state_ff != serial_link_pkg::TX_IDLE) || TX_VALID;
    nxt_dtr_prev = TERMINAL_READY_IN;
    nxt_cable = !CABLE_DETECT_N;
    nxt_mode = mode_ff;
    if (SHUTDOWN_ENTER) begin
      nxt_mode = 1'b1;
    end
    if (SHUTDOWN_EXIT) begin
      nxt_mode = 1'b0;
    end
    nxt_shut = shut_ff;
    if (!nxt_mode) begin
      nxt_shut = 1'b0;
    end else if (SHUTDOWN_ENTER) begin
      nxt_shut = 1'b1;
    end else if (shut_ff && TERMINAL_READY_IN && !dtr_prev_ff) begin
      nxt_shut = 1'b0;
    end else if (!shut_ff && (idle_ff >= 32'(IDLE_CYCLES - 1))) begin
      nxt_shut = 1'b1;
    end
    if (activity || shut_ff || !mode_ff) begin
      nxt_idle = '0;
    end else begin
      nxt_idle = idle_ff + 32'h0000_0001;
    end
    // flow control off leaves cts asserted and unused
    if (FLOW_CONTROL_EN) begin
      nxt_cts = !shut_ff && !nxt_shut && fifo_in_ready;
    end else begin
      nxt_cts = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_ff <= 1'b0;
      shut_ff <= 1'b0;
      idle_ff <= '0;
      dtr_prev_ff <= 1'b1;  // idle ready level, no false rise
      cable_ff <= 1'b0;
      cts_ff <= serial_link_pkg::CTS_RESET;
    end else begin
      mode_ff <= nxt_mode;
      shut_ff <= nxt_shut;
      idle_ff <= nxt_idle;
      dtr_prev_ff <= nxt_dtr_prev;
      cable_ff <= nxt_cable;
      cts_ff <= nxt_cts;
    end
  end

  // rate detection: width of the first start bit sets the divisor
  always_comb begin
    nxt_lock = lock_ff;
    nxt_meas = meas_ff;
    nxt_meas_cnt = meas_cnt_ff;
    nxt_div = div_ff;
    if (!AUTOBAUD_EN) begin
      // fixed rate chosen by the command layer
      nxt_lock = 1'b0;
      nxt_meas = 1'b0;
      nxt_div = FIXED_BAUD_DIV;
    end else if (!lock_ff) begin
      if (!meas_ff && !rxd && !shut_ff) begin
        nxt_meas = 1'b1;
        nxt_meas_cnt = 16'h0001;
      end else if (meas_ff && !rxd) begin
        // saturate on a stuck-low line
        if (meas_cnt_ff != 16'hffff) begin
          nxt_meas_cnt = meas_cnt_ff + 16'h0001;
        end
      end else if (meas_ff) begin
        nxt_meas = 1'b0;
        // glitches shorter than a sane bit are ignored
        if (meas_cnt_ff >= serial_link_pkg::MIN_BIT_DIV) begin
          nxt_lock = 1'b1;
          nxt_div = meas_cnt_ff;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_ff <= 1'b0;
      meas_ff <= 1'b0;
      meas_cnt_ff <= '0;
      div_ff <= serial_link_pkg::BAUD_DIV_DEFAULT;
    end else begin
      lock_ff <= nxt_lock;
      meas_ff <= nxt_meas;
      meas_cnt_ff <= nxt_meas_cnt;
      div_ff <= nxt_div;
    end
  end

  // receiver: mid-bit sampling of 8n1 characters from the terminal
  always_comb begin
    rx_en = !shut_ff && (!AUTOBAUD_EN || lock_ff);
    nxt_rx_state = rx_state_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_rx_shift = rx_shift_ff;
    nxt_ferr = 1'b0;
    nxt_ovr = 1'b0;
    rx_push = 1'b0;
    unique case (rx_state_ff)
      serial_link_pkg::RX_IDLE: begin
        if (rx_en && !rxd) begin
          nxt_rx_state = serial_link_pkg::RX_START;
          nxt_rx_cnt = half_reload(div_ff);
        end
      end
      serial_link_pkg::RX_START: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 16'h0001;
        end else if (!rxd) begin
          nxt_rx_state = serial_link_pkg::RX_DATA;
          nxt_rx_cnt = bit_reload(div_ff);
          nxt_rx_bits = '0;
        end else begin
          // start bit too short, treat as noise
          nxt_rx_state = serial_link_pkg::RX_IDLE;
        end
      end
      serial_link_pkg::RX_DATA: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 16'h0001;
        end else begin
          nxt_rx_shift = {rxd, rx_shift_ff[7:1]};
          nxt_rx_cnt = bit_reload(div_ff);
          nxt_rx_bits = rx_bits_ff + 3'h1;
          if (rx_bits_ff == serial_link_pkg::LAST_BIT) begin
            nxt_rx_state = serial_link_pkg::RX_STOP;
          end
        end
      end
      serial_link_pkg::RX_STOP: begin
        if (rx_cnt_ff != '0) begin
          nxt_rx_cnt = rx_cnt_ff - 16'h0001;
        end else begin
          nxt_rx_state = serial_link_pkg::RX_IDLE;
          if (rxd) begin
            rx_push = 1'b1;
            nxt_ovr = !fifo_in_ready;
          end else begin
            nxt_ferr = 1'b1;
          end
        end
      end
    endcase
    if (shut_ff) begin
      nxt_rx_state = serial_link_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_state_ff <= serial_link_pkg::RX_IDLE;
      rx_cnt_ff <= '0;
      rx_bits_ff <= '0;
      rx_shift_ff <= '0;
      ferr_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bits_ff <= nxt_rx_bits;
      rx_shift_ff <= nxt_rx_shift;
      ferr_ff <= nxt_ferr;
      ovr_ff <= nxt_ovr;
    end
  end

  // receive buffer between the line and the user side
  sync_fifo #(
    .WIDTH(serial_link_pkg::FIFO_WIDTH),
    .DEPTH(serial_link_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_shift_ff),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_DATA)
  );

  // transmitter: 8n1 characters toward the terminal, paced by rts
  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_txd = txd_ff;
    nxt_tx_ready = 1'b0;
    unique case (tx_state_ff)
      serial_link_pkg::TX_IDLE: begin
        nxt_txd = serial_link_pkg::MARK_LEVEL;
        if (tx_ready_ff && TX_VALID) begin
          nxt_tx_state = serial_link_pkg::TX_START;
          nxt_tx_shift = TX_DATA;
          nxt_tx_cnt = bit_reload(div_ff);
          nxt_txd = 1'b0;
        end else begin
          nxt_tx_ready = !shut_ff && (!FLOW_CONTROL_EN || REQUEST_TO_SEND_IN);
        end
      end
      serial_link_pkg::TX_START: begin
        if (tx_cnt_ff != '0) begin
          nxt_tx_cnt = tx_cnt_ff - 16'h0001;
        end else begin
          nxt_tx_state = serial_link_pkg::TX_DATA;
          nxt_txd = tx_shift_ff[0];
          nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          nxt_tx_bits = '0;
          nxt_tx_cnt = bit_reload(div_ff);
        end
      end
      serial_link_pkg::TX_DATA: begin
        if (tx_cnt_ff != '0) begin
          nxt_tx_cnt = tx_cnt_ff - 16'h0001;
        end else begin
          nxt_tx_cnt = bit_reload(div_ff);
          if (tx_bits_ff == serial_link_pkg::LAST_BIT) begin
            nxt_tx_state = serial_link_pkg::TX_STOP;
            nxt_txd = serial_link_pkg::MARK_LEVEL;
          end else begin
            nxt_txd = tx_shift_ff[0];
            nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
            nxt_tx_bits = tx_bits_ff + 3'h1;
          end
        end
      end
      serial_link_pkg::TX_STOP: begin
        if (tx_cnt_ff != '0) begin
          nxt_tx_cnt = tx_cnt_ff - 16'h0001;
        end else begin
          nxt_tx_state = serial_link_pkg::TX_IDLE;
        end
      end
    endcase
    if (shut_ff || nxt_shut) begin
      // powered or going down: line parked at mark
      nxt_tx_state = serial_link_pkg::TX_IDLE;
      nxt_txd = serial_link_pkg::MARK_LEVEL;
      nxt_tx_ready = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_state_ff <= serial_link_pkg::TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bits_ff <= '0;
      tx_shift_ff <= '0;
      txd_ff <= serial_link_pkg::MARK_LEVEL;
      tx_ready_ff <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bits_ff <= nxt_tx_bits;
      tx_shift_ff <= nxt_tx_shift;
      txd_ff <= nxt_txd;
      tx_ready_ff <= nxt_tx_ready;
    end
  end

  // pins and status straight from registers
  assign SERIAL_DATA_TO_TERMINAL = txd_ff;
  assign CLEAR_TO_SEND_OUT = cts_ff;
  assign TX_READY = tx_ready_ff;
  assign RESERVED_SHUTDOWN_LINE = shut_ff;
  assign AUTO_SHUTDOWN_MODE = mode_ff;
  assign CABLE_ATTACHED = cable_ff;
  assign BAUD_LOCKED = lock_ff;
  assign BAUD_DIV = div_ff;
  assign FRAME_ERROR = ferr_ff;
  assign OVERRUN = ovr_ff;
endmodule : serial_link_auto_shutdown

// ---- verif/serial_link_auto_shutdown_props.sv ----
// checker on the top ports of the modem-side serial link
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/10ps
module serial_link_props #(
  parameter int IDLE_CYCLES = 200
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // terminal pins
  input wire logic REQUEST_TO_SEND_IN,
  input wire logic TERMINAL_READY_IN,
  input wire logic CABLE_DETECT_N,
  input wire logic SERIAL_DATA_TO_TERMINAL,
  input wire logic CLEAR_TO_SEND_OUT,
  // control
  input wire logic FLOW_CONTROL_EN,
  input wire logic SHUTDOWN_ENTER,
  input wire logic SHUTDOWN_EXIT,
  // character handshakes
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [7:0] RX_DATA,
  // status
  input wire logic RESERVED_SHUTDOWN_LINE,
  input wire logic AUTO_SHUTDOWN_MODE,
  input wire logic CABLE_ATTACHED
);
  // every property runs on the system clock, off during reset
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  AST_TX_START: assert property (
    TX_VALID && TX_READY && !SHUTDOWN_ENTER
    |=> (!SERIAL_DATA_TO_TERMINAL && !TX_READY) [*4])
    else $error("no held start bit after an accepted character");
  AST_RTS_HOLDS_TX: assert property (
    FLOW_CONTROL_EN && !REQUEST_TO_SEND_IN |=> !TX_READY)
    else $error("character offered while the terminal holds off");
  AST_FLOW_OFF_CTS: assert property (
    !FLOW_CONTROL_EN |=> CLEAR_TO_SEND_OUT)
    else $error("clear to send low with flow control off");
  AST_ENTER: assert property (
    SHUTDOWN_ENTER && !SHUTDOWN_EXIT
    |=> AUTO_SHUTDOWN_MODE && RESERVED_SHUTDOWN_LINE)
    else $error("enter command did not shut the port");
  AST_EXIT: assert property (
    SHUTDOWN_EXIT |=> !AUTO_SHUTDOWN_MODE && !RESERVED_SHUTDOWN_LINE)
    else $error("exit command did not leave the mode");
  AST_WAKE: assert property (
    AUTO_SHUTDOWN_MODE && RESERVED_SHUTDOWN_LINE && !SHUTDOWN_ENTER
    && !SHUTDOWN_EXIT && $rose(TERMINAL_READY_IN)
    |-> ##[1:2] (!RESERVED_SHUTDOWN_LINE && AUTO_SHUTDOWN_MODE))
    else $error("terminal ready rise did not wake the port");
  AST_SHUT_PARKS: assert property (
    RESERVED_SHUTDOWN_LINE && $past(RESERVED_SHUTDOWN_LINE)
    |-> SERIAL_DATA_TO_TERMINAL && !TX_READY)
    else $error("port active while shut down");
  AST_SHUT_CTS: assert property (
    FLOW_CONTROL_EN && $past(FLOW_CONTROL_EN) && RESERVED_SHUTDOWN_LINE
    && $past(RESERVED_SHUTDOWN_LINE) |-> !CLEAR_TO_SEND_OUT)
    else $error("clear to send high while shut down");
  AST_CABLE: assert property (
    $past(RST_N) |-> CABLE_ATTACHED == !$past(CABLE_DETECT_N))
    else $error("cable attached flag wrong");
  AST_RX_HOLDS: assert property (
    RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
    else $error("received character dropped before it was taken");
endmodule : serial_link_props

bind serial_link_auto_shutdown serial_link_props #(
  .IDLE_CYCLES(IDLE_CYCLES)
) serial_link_props_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .REQUEST_TO_SEND_IN(REQUEST_TO_SEND_IN),
  .TERMINAL_READY_IN(TERMINAL_READY_IN), .CABLE_DETECT_N(CABLE_DETECT_N),
  .SERIAL_DATA_TO_TERMINAL(SERIAL_DATA_TO_TERMINAL),
  .CLEAR_TO_SEND_OUT(CLEAR_TO_SEND_OUT), .FLOW_CONTROL_EN(FLOW_CONTROL_EN),
  .SHUTDOWN_ENTER(SHUTDOWN_ENTER), .SHUTDOWN_EXIT(SHUTDOWN_EXIT),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_VALID(RX_VALID),
  .RX_READY(RX_READY), .RX_DATA(RX_DATA),
  .RESERVED_SHUTDOWN_LINE(RESERVED_SHUTDOWN_LINE),
  .AUTO_SHUTDOWN_MODE(AUTO_SHUTDOWN_MODE), .CABLE_ATTACHED(CABLE_ATTACHED)
);

// ---- verif/terminal_model.sv ----
// behavioural terminal on the far side of the serial link
// assumes its pins change at the falling clock edge
`timescale 1ns/10ps
module terminal_model (
  // clock and bit time in cycles
  input wire logic clk,
  input wire logic [15:0] div,
  // pins driven by the modem
  input wire logic cts,
  input wire logic rxd,
  // pins driven by the terminal
  output logic txd,
  output logic rts,
  output logic dtr,
  // last character caught and a running count
  output logic [7:0] last_rx,
  output int n_rx
);
  logic [7:0] sh; // receive shift value
  // idle mark, able to take data, terminal ready high
  initial begin
    txd = 1'b1;
    rts = 1'b1;
    dtr = 1'b1;
    n_rx = 0;
  end
  // one 8n1 character; waits for clear to send unless told not to
  task automatic send(input logic [7:0] b, input logic no_wait,
                      input logic bad_stop);
    logic [9:0] fr;
    int n;
    fr = {~bad_stop, b, 1'b0};
    n = 0;
    while (!no_wait && cts !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 10; i++) begin
      txd = fr[i];
      repeat (div) @(negedge clk);
    end
    txd = 1'b1;
    @(negedge clk); // one mark cycle before the next character
  endtask : send
  // request-to-send level, called at a falling edge
  task automatic set_rts(input logic v);
    rts = v;
  endtask : set_rts
  // low then high on terminal ready asks for wake-up
  task automatic wake();
    dtr = 1'b0;
    @(negedge clk);
    dtr = 1'b1;
    @(negedge clk);
  endtask : wake
  // catch characters from the modem at mid-bit
  always @(negedge rxd) begin
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      sh[i] = rxd;
    end
    last_rx = sh;
    n_rx++;
  end
endmodule : terminal_model

// ---- verif/serial_link_auto_shutdown_tb.sv ----
// self-checking bench for the modem-side serial link
// assumes the terminal model and the checker bind are compiled first
`timescale 1ns/10ps
module serial_link_auto_shutdown_tb;
  localparam int IDLE_SIM = 200; // shortened idle timeout
  // clock, reset and pins
  logic clk, rst_n, txd_t, rts, dtr, cdet_n, rxd_t, cts;
  // control, status and handshakes
  logic flow_en, ab_en, sd_enter, sd_exit, shut_line, sd_mode, cable;
  logic locked, frame_err, overrun, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [7:0] tx_data, rx_data, last_rx;
  logic [15:0] bdiv, baud_div;
  logic [7:0] q[$]; // characters sent into the buffer
  int n_rx;
  int n_mismatch = 0;
  int compares = 0;
  int n_frame = 0; // frame error pulses
  int n_over = 0; // overrun pulses
  serial_link_auto_shutdown #(
    .IDLE_CYCLES(IDLE_SIM)
  ) serial_link_auto_shutdown_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .SERIAL_DATA_FROM_TERMINAL(txd_t),
    .REQUEST_TO_SEND_IN(rts), .TERMINAL_READY_IN(dtr),
    .CABLE_DETECT_N(cdet_n), .SERIAL_DATA_TO_TERMINAL(rxd_t),
    .CLEAR_TO_SEND_OUT(cts), .FLOW_CONTROL_EN(flow_en),
    .AUTOBAUD_EN(ab_en), .FIXED_BAUD_DIV(bdiv), .SHUTDOWN_ENTER(sd_enter),
    .SHUTDOWN_EXIT(sd_exit), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_DATA(rx_data), .RESERVED_SHUTDOWN_LINE(shut_line),
    .AUTO_SHUTDOWN_MODE(sd_mode), .CABLE_ATTACHED(cable),
    .BAUD_LOCKED(locked), .BAUD_DIV(baud_div), .FRAME_ERROR(frame_err),
    .OVERRUN(overrun)
  );
  terminal_model terminal_model_inst (
    .clk(clk), .div(bdiv), .cts(cts), .rxd(rxd_t), .txd(txd_t), .rts(rts),
    .dtr(dtr), .last_rx(last_rx), .n_rx(n_rx)
  );
  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count error pulses
  always @(negedge clk) begin
    if (frame_err === 1'b1) n_frame++;
    if (overrun === 1'b1) n_over++;
  end
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // measured divisor may be one cycle off the true bit time
  function automatic logic near(input logic [15:0] d, input logic [15:0] w);
    return (d + 16'h0001 >= w) && (d <= w + 16'h0001);
  endfunction : near
  // one character toward the terminal, caught by the model
  task automatic send_tx(input logic [7:0] b);
    int n, k;
    n = 0;
    k = n_rx;
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    tx_valid = 1'b0;
    while (n_rx == k && n < 6000) begin
      @(negedge clk);
      n++;
    end
    repeat (2 * bdiv) @(negedge clk); // let the stop bit pass
    check(16'(last_rx), 16'(b));
  endtask : send_tx
  // take one character from the receive side
  task automatic exp_rx(input logic [7:0] b);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(16'(rx_data), 16'(b));
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask : exp_rx
  // discard whatever the receiver holds
  task automatic flush();
    rx_ready = 1'b1;
    repeat (300) @(negedge clk);
    rx_ready = 1'b0;
  endtask : flush
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // main sequence
  initial begin
    logic [7:0] b;
    void'($urandom(32'hd904));
    rst_n = 1'b0;
    cdet_n = 1'b0;
    flow_en = 1'b1;
    ab_en = 1'b0;
    bdiv = 16'h0010;
    sd_enter = 1'b0;
    sd_exit = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({rxd_t, cts, tx_ready, rx_valid, shut_line, sd_mode}),
          16'h0020);
    check(baud_div, 16'h0364);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(16'(cable), 16'h0001);
    check(baud_div, 16'h0010);
    cdet_n = 1'b1;
    repeat (2) @(negedge clk);
    check(16'(cable), 16'h0000);
    cdet_n = 1'b0;
    // characters toward the terminal, all-zero and all-one first
    for (int i = 0; i < 5; i++) begin
      b = (i < 2) ? {8{i[0]}} : 8'($urandom);
      send_tx(b);
    end
    // terminal holds off, then flow control switched off
    terminal_model_inst.set_rts(1'b0);
    repeat (2) @(negedge clk);
    check(16'(tx_ready), 16'h0000);
    flow_en = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({cts, tx_ready}), 16'h0003);
    flow_en = 1'b1;
    terminal_model_inst.set_rts(1'b1);
    // characters from the terminal
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      terminal_model_inst.send(b, 1'b0, 1'b0);
      exp_rx(b);
    end
    // fill the buffer until clear to send drops, overrun, then drain
    for (int i = 0; i < 9; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      terminal_model_inst.send(b, 1'b0, 1'b0);
    end
    repeat (40) @(negedge clk);
    check(16'(cts), 16'h0000);
    terminal_model_inst.send(8'h5a, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    check(16'(n_over), 16'h0001);
    while (q.size() > 0) exp_rx(q.pop_front());
    check(16'({cts, rx_valid}), 16'h0002);
    // low stop bit
    terminal_model_inst.send(8'h33, 1'b0, 1'b1);
    repeat (20) @(negedge clk);
    check(16'(n_frame), 16'h0001);
    flush();
    // auto shutdown: enter, ignore traffic, wake, idle again, exit
    sd_enter = 1'b1;
    @(negedge clk);
    sd_enter = 1'b0;
    check(16'({sd_mode, shut_line, tx_ready}), 16'h0006);
    terminal_model_inst.send(8'h77, 1'b1, 1'b0);
    repeat (20) @(negedge clk);
    check(16'(rx_valid), 16'h0000);
    terminal_model_inst.wake();
    @(negedge clk);
    check(16'({sd_mode, shut_line}), 16'h0002);
    repeat (IDLE_SIM + 20) @(negedge clk);
    check(16'(shut_line), 16'h0001);
    sd_exit = 1'b1;
    @(negedge clk);
    sd_exit = 1'b0;
    check(16'({sd_mode, shut_line}), 16'h0000);
    send_tx(8'hc3);
    // rate detection from a character whose first data bit is one
    ab_en = 1'b1;
    bdiv = 16'h0014;
    @(negedge clk);
    terminal_model_inst.send(8'h41, 1'b0, 1'b0);
    check(16'({locked, near(baud_div, 16'h0014)}), 16'h0003);
    flush();
    wrap_up();
  end
endmodule : serial_link_auto_shutdown_tb
